// *** verilog/dadc_readout.sv ***
// dual simultaneous-sampling converter: frame control and serial result shifter
// assumes select and serial clock come from a host and are asynchronous to CLK
`default_nettype none

module dadc_readout #(
   parameter bit HIGH_RES = 1'b1
) (
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // host link pins
   input wire logic SELECT_N,
   input wire logic SERIAL_CLK,
   output logic CHANNEL_A_SERIAL_OUT,
   output logic CHANNEL_A_SERIAL_OE_N,
   output logic CHANNEL_B_SERIAL_OUT,
   output logic CHANNEL_B_SERIAL_OE_N,
   // digitised input levels, same clock domain
   input wire logic signed [dadc_pkg::SAMPLE_W-1:0] LEVEL_A,
   input wire logic signed [dadc_pkg::SAMPLE_W-1:0] LEVEL_B,
   // status
   output logic CONVERTING,
   output logic FRAME_ABORT
);
   localparam int RES_W = HIGH_RES ? dadc_pkg::HI_RES_BITS : dadc_pkg::LO_RES_BITS;
   localparam int PAD_W = dadc_pkg::SHIFT_W - RES_W;
   localparam logic [dadc_pkg::CNT_W-1:0] RES_CNT = dadc_pkg::CNT_W'(RES_W);
   localparam logic [dadc_pkg::CNT_W-1:0] NEED_RISE =
      dadc_pkg::CNT_W'(RES_W + dadc_pkg::EXTRA_RISE);
   localparam logic signed [dadc_pkg::SAMPLE_W-1:0] POS_LIM =
      dadc_pkg::SAMPLE_W'((1 << (RES_W - 1)) - 1);
   localparam logic signed [dadc_pkg::SAMPLE_W-1:0] NEG_LIM =
      dadc_pkg::SAMPLE_W'(-(1 << (RES_W - 1)));

   logic cs_s1, cs_s2, cs_s3;
   logic sck_s1, sck_s2, sck_s3;
   logic in_frame;
   logic [dadc_pkg::CNT_W-1:0] fall_cnt, rise_cnt;
   logic [dadc_pkg::SHIFT_W-1:0] shift_a, shift_b;
   logic out_a, out_b, oe_n, abort_p;
   wire cs_fall, cs_rise, sck_fall, sck_rise, launch;
   wire signed [dadc_pkg::SAMPLE_W-1:0] clamp_a, clamp_b;
   wire [dadc_pkg::SHIFT_W-1:0] load_a, load_b;

   // two-stage synchronisers plus a third stage for edge detection
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
      end
      else if (CE)
      begin
         cs_s1 <= SELECT_N;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         sck_s1 <= SERIAL_CLK;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
      end
   end

   // edge decode
   assign cs_fall = cs_s3 & ~cs_s2; // frame opens
   assign cs_rise = ~cs_s3 & cs_s2; // frame closes
   assign sck_fall = sck_s3 & ~sck_s2 & in_frame & ~cs_rise;
   assign sck_rise = ~sck_s3 & sck_s2 & in_frame & ~cs_rise;
   assign launch = sck_fall & (fall_cnt != dadc_pkg::CNT_RST); // second edge on

   // clamp to full scale, keep low bits as twos complement code
   assign clamp_a = (LEVEL_A > POS_LIM) ? POS_LIM : (LEVEL_A < NEG_LIM) ? NEG_LIM : LEVEL_A;
   assign clamp_b = (LEVEL_B > POS_LIM) ? POS_LIM : (LEVEL_B < NEG_LIM) ? NEG_LIM : LEVEL_B;
   // left-justify the code in the shifter, zero pad below it
   assign load_a = dadc_pkg::SHIFT_W'(clamp_a[RES_W-1:0]) << PAD_W;
   assign load_b = dadc_pkg::SHIFT_W'(clamp_b[RES_W-1:0]) << PAD_W;

   // frame tracking and edge counters
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         in_frame <= 1'b0;
         fall_cnt <= dadc_pkg::CNT_RST;
         rise_cnt <= dadc_pkg::CNT_RST;
         abort_p <= 1'b0;
      end
      else if (CE)
      begin
         abort_p <= cs_rise & in_frame & (rise_cnt < NEED_RISE);
         if (cs_fall)
         begin
            in_frame <= 1'b1;
            fall_cnt <= dadc_pkg::CNT_RST;
            rise_cnt <= dadc_pkg::CNT_RST;
         end
         else if (cs_rise)
            in_frame <= 1'b0; // early rise drops the frame, sampling resumes
         else
         begin
            if (sck_fall && fall_cnt != dadc_pkg::CNT_MAX)
               fall_cnt <= fall_cnt + 1'b1;
            if (sck_rise && rise_cnt != dadc_pkg::CNT_MAX)
               rise_cnt <= rise_cnt + 1'b1;
         end
      end
   end

   // both channels held on the same edge, shifted in parallel
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         shift_a <= dadc_pkg::SHIFT_RST;
         shift_b <= dadc_pkg::SHIFT_RST;
      end
      else if (CE)
      begin
         if (cs_fall)
         begin
            shift_a <= load_a;
            shift_b <= load_b;
         end
         else if (launch)
         begin
            shift_a <= {shift_a[dadc_pkg::SHIFT_W-2:0], 1'b0}; // zeros fill
            shift_b <= {shift_b[dadc_pkg::SHIFT_W-2:0], 1'b0};
         end
      end
   end

   // pin drivers
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         out_a <= dadc_pkg::OUT_RST;
         out_b <= dadc_pkg::OUT_RST;
         oe_n <= dadc_pkg::OE_N_RST;
      end
      else if (CE)
      begin
         if (cs_fall)
         begin
            oe_n <= 1'b0;
            out_a <= 1'b0;
            out_b <= 1'b0;
         end
         else if (cs_rise)
         begin
            oe_n <= 1'b1;
            out_a <= dadc_pkg::OUT_RST;
            out_b <= dadc_pkg::OUT_RST;
         end
         else if (sck_fall)
         begin
            out_a <= launch & shift_a[dadc_pkg::SHIFT_W-1]; // MSB first
            out_b <= launch & shift_b[dadc_pkg::SHIFT_W-1];
         end
      end
   end

   // outputs
   assign CHANNEL_A_SERIAL_OUT = out_a;
   assign CHANNEL_B_SERIAL_OUT = out_b;
   assign CHANNEL_A_SERIAL_OE_N = oe_n;
   assign CHANNEL_B_SERIAL_OE_N = oe_n;
   assign CONVERTING = in_frame & (rise_cnt < RES_CNT);
   assign FRAME_ABORT = abort_p;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_open;
      CE && cs_fall;
   endsequence
   sequence s_driven_zero;
      !oe_n && !out_a && !out_b;
   endsequence

   property p_enable_on_open;
      s_open |=> s_driven_zero;
   endproperty
   a_enable_on_open: assert property (p_enable_on_open)
      else $error("outputs not enabled low");

   property p_tristate_on_close;
      CE && cs_rise |=> oe_n && !in_frame;
   endproperty
   a_tristate_on_close: assert property (p_tristate_on_close)
      else $error("outputs not released");

   property p_same_sample;
      s_open |=> (shift_a == $past(load_a)) && (shift_b == $past(load_b)) && in_frame;
   endproperty
   a_same_sample: assert property (p_same_sample)
      else $error("channels not held together");

   property p_clamp_high;
      LEVEL_A > POS_LIM |->
         load_a[dadc_pkg::SHIFT_W-1] == 1'b0 && load_a[dadc_pkg::SHIFT_W-2 -: 2] == 2'h3;
   endproperty
   a_clamp_high: assert property (p_clamp_high) else $error("over-range not clamped");

   property p_zero_code;
      LEVEL_B == '0 |-> load_b == dadc_pkg::zero_input_code;
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("zero input not zero code");

   property p_first_fall_zero;
      CE && sck_fall && fall_cnt == dadc_pkg::CNT_RST |=> !out_a && !out_b;
   endproperty
   a_first_fall_zero: assert property (p_first_fall_zero)
      else $error("first edge not zero");

   property p_msb_launch;
      CE && launch |=> out_a == $past(shift_a[dadc_pkg::SHIFT_W-1]);
   endproperty
   a_msb_launch: assert property (p_msb_launch) else $error("wrong bit launched");

   property p_trailing_zero;
      CE && sck_fall && fall_cnt > RES_CNT |=> !out_a && !out_b;
   endproperty
   a_trailing_zero: assert property (p_trailing_zero)
      else $error("extra edge not zero");

   property p_abort;
      CE && cs_rise && in_frame && rise_cnt < NEED_RISE |=> FRAME_ABORT ##1 !FRAME_ABORT || !CE;
   endproperty
   a_abort: assert property (p_abort) else $error("short frame not aborted");

   property p_conv_end;
      CE && sck_rise && rise_cnt == RES_CNT - 1'b1 |=> !CONVERTING;
   endproperty
   a_conv_end: assert property (p_conv_end)
      else $error("conversion overruns");

   property p_conv_start;
      s_open |=> CONVERTING;
   endproperty
   a_conv_start: assert property (p_conv_start)
      else $error("conversion not started");
endmodule : dadc_readout
`default_nettype wire

// *** verilog/dadc_pkg.sv ***
// constants for the dual-channel converter serial readout
// assumes a single 10 MHz system clock samples the select and serial clock pins
`default_nettype none
package dadc_pkg;
   // result widths of the two variants
   localparam int HI_RES_BITS = 14;
   localparam int LO_RES_BITS = 12;
   // width of the output shift register, results sit left-justified in it
   localparam int SHIFT_W = 14;
   // width of the digitised input level presented to each converter
   localparam int SAMPLE_W = 16;
   // width of the edge counters, which saturate
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
   // rising edges beyond the result width needed to finish a frame
   localparam int EXTRA_RISE = 2;
   // reset values of the pins, counters and shift register
   localparam logic OUT_RST = 1'b0;
   localparam logic OE_N_RST = 1'b1;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic [SHIFT_W-1:0] SHIFT_RST = 14'h0000;
   // zero input code
   localparam logic [SHIFT_W-1:0] zero_input_code = 14'h0000;
endpackage : dadc_pkg
`default_nettype wire

// *** verif/dadc_host.sv ***
// host controller model: frames the link and captures both data lines
// assumes levels change on CLK rising edges, 8 CLK per serial period
`default_nettype none
module dadc_host (
   // system clock
   input wire logic clk,
   // link pins
   output logic select_n,
   output logic serial_clk,
   input wire logic a_out,
   input wire logic a_oe_n,
   input wire logic b_out,
   input wire logic b_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   wire a_seen;
   wire b_seen;
   // a released line reads as the inverse of its last value
   assign a_seen = a_oe_n ? ~a_out : a_out;
   assign b_seen = b_oe_n ? ~b_out : b_out;
   // idle: deselected, serial clock parked high
   initial
   begin
      select_n = 1'b1;
      serial_clk = 1'b1;
   end
   // one frame of n rising edges, bits shifted in lsb side
   task automatic frame(input int n, output logic [19:0] cap_a, output logic [19:0] cap_b);
      cap_a = 20'h00000;
      cap_b = 20'h00000;
      @(posedge clk);
      select_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         serial_clk <= 1'b0;
         repeat (4) @(posedge clk);
         serial_clk <= 1'b1;
         cap_a = {cap_a[18:0], a_seen};
         cap_b = {cap_b[18:0], b_seen};
         repeat (4) @(posedge clk);
      end
      select_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : frame
endmodule : dadc_host
`default_nettype wire

// *** verif/tb.sv ***
// bench for the dual converter readout, 14-bit and 12-bit variants side by side
// assumes the host model drives the link; levels driven by the bench
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [15:0] la; logic [15:0] lb; logic [13:0] ea; logic [13:0] eb;
      logic [11:0] ea12; logic [11:0] eb12; int n;} dadc_row_s;
   logic clk, rst_n, ce, sel_n, sclk, a, a_oe_n, b, b_oe_n, conv, abort;
   logic a12, a12_oe_n, b12, b12_oe_n, conv12, abort12;
   logic signed [15:0] level_a, level_b;
   logic [19:0] cap_a, cap_b, cap_a12, cap_b12;
   int num_errors, n_tests, n_conv, n_abort, n_conv12, n_abort12;
   // levels, 14-bit and 12-bit codes and rising-edge counts of each frame
   dadc_row_s rows [8] = '{
      '{16'h0000, 16'hffff, 14'h0000, 14'h3fff, 12'h000, 12'hfff, 16},
      '{16'h1fff, 16'he000, 14'h1fff, 14'h2000, 12'h7ff, 12'h800, 16},
      '{16'h4e20, 16'h8ad0, 14'h1fff, 14'h2000, 12'h7ff, 12'h800, 16},
      '{16'h1234, 16'he001, 14'h1234, 14'h2001, 12'h7ff, 12'h800, 18},
      '{16'h0a5c, 16'h15a3, 14'h0a5c, 14'h15a3, 12'h7ff, 12'h7ff, 5},
      '{16'h0f0f, 16'hfffe, 14'h0f0f, 14'h3ffe, 12'h7ff, 12'hffe, 14},
      '{16'h0001, 16'h1000, 14'h0001, 14'h1000, 12'h001, 12'h7ff, 16},
      '{16'h0123, 16'hf9ab, 14'h0123, 14'h39ab, 12'h123, 12'h9ab, 12}};
   dadc_readout uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .SELECT_N(sel_n), .SERIAL_CLK(sclk),
      .CHANNEL_A_SERIAL_OUT(a), .CHANNEL_A_SERIAL_OE_N(a_oe_n), .CHANNEL_B_SERIAL_OUT(b),
      .CHANNEL_B_SERIAL_OE_N(b_oe_n), .LEVEL_A(level_a), .LEVEL_B(level_b),
      .CONVERTING(conv), .FRAME_ABORT(abort));
   dadc_host h (.clk(clk), .select_n(sel_n), .serial_clk(sclk), .a_out(a), .a_oe_n(a_oe_n),
      .b_out(b), .b_oe_n(b_oe_n));
   // 12-bit variant on the same link and levels
   dadc_readout #(.HIGH_RES(1'b0)) uut12 (.CLK(clk), .RST_N(rst_n), .CE(ce), .SELECT_N(sel_n),
      .SERIAL_CLK(sclk), .CHANNEL_A_SERIAL_OUT(a12), .CHANNEL_A_SERIAL_OE_N(a12_oe_n),
      .CHANNEL_B_SERIAL_OUT(b12), .CHANNEL_B_SERIAL_OE_N(b12_oe_n), .LEVEL_A(level_a),
      .LEVEL_B(level_b), .CONVERTING(conv12), .FRAME_ABORT(abort12));
   // 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // busy cycles and abort pulses per frame
   always @(posedge clk)
   begin
      if (conv === 1'b1) n_conv++;
      if (abort === 1'b1) n_abort++;
      if (conv12 === 1'b1) n_conv12++;
      if (abort12 === 1'b1) n_abort12++;
   end
   // host-side capture of the 12-bit lines, a released line reads inverted
   always @(posedge sclk)
   begin
      if (sel_n === 1'b0)
      begin
         cap_a12 = {cap_a12[18:0], a12_oe_n ? ~a12 : a12};
         cap_b12 = {cap_b12[18:0], b12_oe_n ? ~b12 : b12};
      end
   end
   task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   // captured bits: zero, code msb first, then zeros
   function automatic logic [19:0] exp_cap(input logic [13:0] code, input int n);
      logic [19:0] full;
      full = {5'h00, code, 1'b0};
      return (n >= 16) ? full << (n - 16) : full >> (16 - n);
   endfunction : exp_cap
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // watchdog, frames need about 1300 cycles
   initial
   begin
      #400000;
      num_errors++;
      stop_test();
   end
   // reset, table of frames, then a mid-run reset
   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      level_a = 16'h0000;
      level_b = 16'h0000;
      num_errors = 0;
      n_tests = 0;
      repeat (16) @(posedge clk);
      check("reset pins", 20'h0000c, {a, b, a_oe_n, b_oe_n, conv, abort});
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i])
      begin
         level_a <= rows[i].la;
         level_b <= rows[i].lb;
         n_conv = 0;
         n_abort = 0;
         n_conv12 = 0;
         n_abort12 = 0;
         cap_a12 = 20'h00000;
         cap_b12 = 20'h00000;
         h.frame(rows[i].n, cap_a, cap_b);
         check("data a", exp_cap(rows[i].ea, rows[i].n), cap_a);
         check("data b", exp_cap(rows[i].eb, rows[i].n), cap_b);
         check("data a12", exp_cap({rows[i].ea12, 2'h0}, rows[i].n), cap_a12);
         check("data b12", exp_cap({rows[i].eb12, 2'h0}, rows[i].n), cap_b12);
         check("abort", {19'h0, rows[i].n < 16}, 20'(n_abort));
         check("abort12", {19'h0, rows[i].n < 14}, 20'(n_abort12));
         if (rows[i].n >= 14)
            check("busy", 20'h00001, {19'h0, n_conv >= 111 && n_conv <= 113});
         if (rows[i].n >= 12)
            check("busy12", 20'h00001, {19'h0, n_conv12 >= 95 && n_conv12 <= 97});
         check("release", 20'h0000c, {a, b, a_oe_n, b_oe_n, conv, abort});
         check("rel12", 20'h0000c, {a12, b12, a12_oe_n, b12_oe_n, conv12, abort12});
      end
      // frozen clock enable: a whole frame goes unseen
      ce <= 1'b0;
      n_conv = 0;
      h.frame(16, cap_a, cap_b);
      check("frozen", 20'h0000c, {a, b, a_oe_n, b_oe_n, conv, abort});
      check("frozen busy", 20'h00000, 20'(n_conv));
      ce <= 1'b1;
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      check("mid reset", 20'h0000c, {a, b, a_oe_n, b_oe_n, conv, abort});
      rst_n <= 1'b1;
      level_a <= 16'h0abc;
      @(posedge clk);
      h.frame(16, cap_a, cap_b);
      check("after reset", exp_cap(14'h0abc, 16), cap_a);
      stop_test();
   end
endmodule : tb
`default_nettype wire
